// ==== hw/mfp_pin_ctrl.sv ====
// Multi-function pin mux, pin clock divider, interrupt pulser and codec clock select
//
// Operation
// - Upper nibble selects pin function; zero disables the pin.
// - Code 0001 drives the ADC word clock onto the pin.
// - Codes 0010 to 0101 output the clock mux divided by 1, 2, 4, 8.
// - Code 0110 outputs short-circuit interrupt; 0111 the AGC noise interrupt.
// - Code 1000 makes the pin an input; 1001 makes it an output.
// - Read-only bit shows the level present on the pin.
// - In output mode the pin follows the output value bit.
// - Code 1011 makes the pin the bus word clock, direction from master mode.
// - Code 1100 outputs the active-high button interrupt level.
// - Codes 1101 and 1110 output headset OR button interrupt.
// - Code 1111 outputs OR of headset, button, short and AGC interrupts.
// - Clock source bit picks PLL output or divider mux for the pin divider.
// - Duration bit clear: each interrupt is one high pulse of about 2 ms.
// - Duration bit set: pulses repeat until the flags register is read.
// - One bit picks pll divided or bypass divider clock for the codec core.
// - Two reserved registers read zero; host never writes them.
// - Upper seven bits of the clock source register read zero.
// - Button flag is sticky until its status register is read.
`timescale 1ns/1ps
`include "mfp_params.svh"

module mfp_pin_ctrl #(
    parameter int PULSE_US  = `MFP_IRQ_PULSE_US,
    parameter int CLK_KHZ   = `MFP_CLK_KHZ,
    parameter int PULSE_CYC = (PULSE_US * CLK_KHZ) / 1000
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Register access
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    input  wire logic [6:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // Status reads elsewhere that clear pin state
    input  wire logic       irq_flags_read_in,
    input  wire logic       button_status_read_in,
    // Interrupt sources
    input  wire logic       short_irq_in,
    input  wire logic       agc_noise_irq_in,
    input  wire logic       headset_irq_in,
    input  wire logic       button_irq_in,
    // Clock sources, sampled as ordinary levels
    input  wire logic       pll_clock_in,
    input  wire logic       clkdiv_mux_in,
    input  wire logic       pll_divided_clock_in,
    input  wire logic       bypass_divider_clock_in,
    input  wire logic       adc_word_clock_in,
    input  wire logic       bus_word_clock_in,
    input  wire logic       bus_master_in,
    // Multi-function pin
    input  wire logic       multi_function_pin_in,
    output logic            multi_function_pin_out,
    output logic            multi_function_pin_oe_out,
    // Results
    output logic            codec_core_clock_input_out,
    output logic            word_clock_from_pin_out,
    output logic            button_sticky_out
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Interrupt source that feeds the pulse generator for each code
    function automatic logic irq_select(input logic [3:0] fn,
                                        input mfp_pkg::mfp_irq_src_t src);
        case (fn)
            `MFP_FN_SHORT_IRQ:  irq_select = src.short_circuit;
            `MFP_FN_AGC_IRQ:    irq_select = src.agc_noise;
            `MFP_FN_JACK_IRQ_A,
            `MFP_FN_JACK_IRQ_B: irq_select = src.headset | src.button;
            `MFP_FN_ALL_IRQ:    irq_select = src.headset | src.button
                                           | src.short_circuit | src.agc_noise;
            default:            irq_select = 1'b0;
        endcase
    endfunction

    // True for codes that route through the pulse generator
    function automatic logic is_pulsed(input logic [3:0] fn);
        is_pulsed = (fn == `MFP_FN_SHORT_IRQ) || (fn == `MFP_FN_AGC_IRQ)
                 || (fn == `MFP_FN_JACK_IRQ_A) || (fn == `MFP_FN_JACK_IRQ_B)
                 || (fn == `MFP_FN_ALL_IRQ);
    endfunction

    localparam logic [`MFP_IRQ_CNT_W-1:0] PULSE_LAST = (`MFP_IRQ_CNT_W)'(PULSE_CYC - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mfp_pkg::mfp_state_t   s;
    mfp_pkg::mfp_state_t   next_s;
    mfp_pkg::mfp_irq_src_t src;
    logic                  sel_clk;
    logic                  clk_rise;
    logic                  irq_level;
    logic                  irq_rise;

    assign src = '{short_circuit: short_irq_in, agc_noise: agc_noise_irq_in,
                   headset: headset_irq_in, button: button_irq_in};

    // Pin clock source and its rising edge
    assign sel_clk   = s.clk_sel ? clkdiv_mux_in : pll_clock_in;
    assign clk_rise  = sel_clk & ~s.clk_prev;
    assign irq_level = irq_select(s.func, src);
    assign irq_rise  = irq_level & ~s.irq_prev;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;

        // Synchroniser: first stage only feeds the second
        next_s.sync1 = multi_function_pin_in;
        next_s.sync2 = s.sync1;

        // Register writes; reserved registers and read-only bits ignore them
        if (reg_wr_in) begin
            if (reg_addr_in == `MFP_OFS_PIN_CTRL) begin
                next_s.func     = reg_wdata_in[`MFP_FLD_FUNC_HI:`MFP_FLD_FUNC_LO];
                next_s.clk_sel  = reg_wdata_in[`MFP_FLD_CLK_SEL];
                next_s.duration = reg_wdata_in[`MFP_FLD_DURATION];
                next_s.gp_value = reg_wdata_in[`MFP_FLD_GP_VALUE];
            end else if (reg_addr_in == `MFP_OFS_CLK_SRC) begin
                next_s.core_sel = reg_wdata_in[`MFP_FLD_CORE_SEL];
            end
        end

        // Register reads, one cycle latency; unmapped and reserved read zero
        if (reg_rd_in) begin
            case (reg_addr_in)
                `MFP_OFS_PIN_CTRL: next_s.rdata = {s.func, s.clk_sel, s.duration,
                                                   s.sync2, s.gp_value};
                `MFP_OFS_CLK_SRC:  next_s.rdata = {7'h00, s.core_sel};
                `MFP_OFS_RSVD_A,
                `MFP_OFS_RSVD_B:   next_s.rdata = `MFP_RST_RSVD;
                default:           next_s.rdata = 8'h00;
            endcase
        end

        // Pin clock divider counts rising edges of the selected source
        next_s.clk_prev = sel_clk;
        if (clk_rise) begin
            next_s.div_cnt = s.div_cnt + 3'h1;
        end

        // Interrupt pulse generator; a new event beats a flags read
        next_s.irq_prev = irq_level;
        case (s.irq_st)
            mfp_pkg::MFP_IRQ_IDLE: begin
                if (irq_rise) begin
                    next_s.irq_st  = mfp_pkg::MFP_IRQ_HIGH;
                    next_s.irq_cnt = '0;
                end
            end
            mfp_pkg::MFP_IRQ_HIGH: begin
                if (irq_rise && s.duration) begin
                    next_s.irq_cnt = '0;
                end else if (s.duration && irq_flags_read_in) begin
                    next_s.irq_st = mfp_pkg::MFP_IRQ_IDLE;
                end else if (s.irq_cnt == PULSE_LAST) begin
                    next_s.irq_cnt = '0;
                    next_s.irq_st  = s.duration ? mfp_pkg::MFP_IRQ_LOW
                                                : mfp_pkg::MFP_IRQ_IDLE;
                end else begin
                    next_s.irq_cnt = s.irq_cnt + 1'b1;
                end
            end
            mfp_pkg::MFP_IRQ_LOW: begin
                if (irq_rise) begin
                    next_s.irq_st  = mfp_pkg::MFP_IRQ_HIGH;
                    next_s.irq_cnt = '0;
                end else if (irq_flags_read_in || !s.duration) begin
                    next_s.irq_st = mfp_pkg::MFP_IRQ_IDLE;
                end else if (s.irq_cnt == PULSE_LAST) begin
                    next_s.irq_cnt = '0;
                    next_s.irq_st  = mfp_pkg::MFP_IRQ_HIGH;
                end else begin
                    next_s.irq_cnt = s.irq_cnt + 1'b1;
                end
            end
            default: begin
                next_s.irq_st = mfp_pkg::MFP_IRQ_IDLE;
            end
        endcase
        // Leaving the interrupt modes drops any pulse in flight
        if (!is_pulsed(s.func)) begin
            next_s.irq_st = mfp_pkg::MFP_IRQ_IDLE;
        end

        // Pin function mux
        next_s.pin = '{out: 1'b0, oe: 1'b0};
        next_s.wclk_from_pin = 1'b0;
        case (s.func)
            `MFP_FN_DISABLED:   next_s.pin = '{out: 1'b0, oe: 1'b0};
            `MFP_FN_ADC_WCLK:   next_s.pin = '{out: adc_word_clock_in, oe: 1'b1};
            `MFP_FN_DIV1:       next_s.pin = '{out: sel_clk, oe: 1'b1};
            `MFP_FN_DIV2:       next_s.pin = '{out: s.div_cnt[0], oe: 1'b1};
            `MFP_FN_DIV4:       next_s.pin = '{out: s.div_cnt[1], oe: 1'b1};
            `MFP_FN_DIV8:       next_s.pin = '{out: s.div_cnt[2], oe: 1'b1};
            `MFP_FN_GP_IN:      next_s.pin = '{out: 1'b0, oe: 1'b0};
            `MFP_FN_GP_OUT:     next_s.pin = '{out: s.gp_value, oe: 1'b1};
            `MFP_FN_BUS_WCLK: begin
                // Slave mode hands the pin's synchronised level to the bus
                if (bus_master_in) begin
                    next_s.pin = '{out: bus_word_clock_in, oe: 1'b1};
                end else begin
                    next_s.wclk_from_pin = s.sync2;
                end
            end
            `MFP_FN_BUTTON_IRQ: next_s.pin = '{out: button_irq_in, oe: 1'b1};
            `MFP_FN_RESERVED:   next_s.pin = '{out: 1'b0, oe: 1'b0};
            default: begin
                next_s.pin = '{out: (s.irq_st == mfp_pkg::MFP_IRQ_HIGH), oe: 1'b1};
            end
        endcase

        // Codec core clock select, registered as a sampled level
        next_s.core_clk = s.core_sel ? bypass_divider_clock_in
                                     : pll_divided_clock_in;

        // Sticky button flag: a press in the clearing cycle stays set
        if (button_irq_in) begin
            next_s.button_sticky = 1'b1;
        end else if (button_status_read_in) begin
            next_s.button_sticky = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s          <= '0;
            s.irq_st   <= mfp_pkg::MFP_IRQ_IDLE;
            s.func     <= 4'(`MFP_RST_PIN_CTRL >> `MFP_FLD_FUNC_LO);
            s.core_sel <= 1'(`MFP_RST_CLK_SRC);
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from state flip-flops
    assign reg_rdata_out              = s.rdata;
    assign multi_function_pin_out     = s.pin.out;
    assign multi_function_pin_oe_out  = s.pin.oe;
    assign codec_core_clock_input_out = s.core_clk;
    assign word_clock_from_pin_out    = s.wclk_from_pin;
    assign button_sticky_out          = s.button_sticky;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking mfp_cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence seq_read(logic [6:0] ofs);
        reg_rd_in && !reg_wr_in && reg_addr_in == ofs;
    endsequence

    sequence seq_train_stop;
        s.duration && s.irq_st == mfp_pkg::MFP_IRQ_LOW && irq_flags_read_in
        && !irq_rise && is_pulsed(s.func) && !reg_wr_in;
    endsequence

    a_disabled_pin_off: assert property (
        s.func == `MFP_FN_DISABLED |=> !multi_function_pin_oe_out)
        else $error("Disabled pin is driven");

    a_adc_wclk_route: assert property (
        s.func == `MFP_FN_ADC_WCLK |=> multi_function_pin_oe_out
            && multi_function_pin_out == $past(adc_word_clock_in))
        else $error("ADC word clock not on pin");

    a_gp_out_level: assert property (
        s.func == `MFP_FN_GP_OUT |=> multi_function_pin_oe_out
            && multi_function_pin_out == $past(s.gp_value))
        else $error("Output mode level wrong");

    a_gp_in_float: assert property (
        s.func == `MFP_FN_GP_IN |=> !multi_function_pin_oe_out)
        else $error("Input mode drives pin");

    a_pin_sync_path: assert property (
        ##2 s.sync2 == $past(multi_function_pin_in, 2))
        else $error("Pin level not two stages late");

    a_level_readback: assert property (
        seq_read(`MFP_OFS_PIN_CTRL) |=> reg_rdata_out[`MFP_FLD_PIN_LEVEL]
            == $past(multi_function_pin_in, 3))
        else $error("Pin level readback wrong");

    a_reserved_zero: assert property (
        (seq_read(`MFP_OFS_RSVD_A) or seq_read(`MFP_OFS_RSVD_B)) |=> reg_rdata_out == 8'h00)
        else $error("Reserved register not zero");

    a_clksrc_upper: assert property (
        seq_read(`MFP_OFS_CLK_SRC) |=> reg_rdata_out[7:1] == 7'h00
            && reg_rdata_out[0] == $past(s.core_sel))
        else $error("Clock source readback wrong");

    a_core_clk_mux: assert property (
        1'b1 |=> codec_core_clock_input_out == ($past(s.core_sel)
            ? $past(bypass_divider_clock_in) : $past(pll_divided_clock_in)))
        else $error("Codec core clock source wrong");

    a_wclk_slave_dir: assert property (
        s.func == `MFP_FN_BUS_WCLK && !bus_master_in |=> !multi_function_pin_oe_out)
        else $error("Slave word clock pin driven");

    a_train_stops: assert property (
        seq_train_stop |=> s.irq_st == mfp_pkg::MFP_IRQ_IDLE ##1 !multi_function_pin_out)
        else $error("Pulse train did not stop on flags read");

    a_pulse_starts: assert property (
        s.irq_st == mfp_pkg::MFP_IRQ_IDLE && irq_rise && !reg_wr_in
            |=> s.irq_st == mfp_pkg::MFP_IRQ_HIGH ##1 multi_function_pin_out)
        else $error("Interrupt pulse did not start");

    a_sticky_holds: assert property (
        button_sticky_out && !button_status_read_in |=> button_sticky_out)
        else $error("Button flag dropped early");

    // A press in the clearing cycle must still leave the flag set
    a_sticky_sets: assert property (
        button_irq_in |=> button_sticky_out)
        else $error("Button press not latched");

    // Button code bypasses the pulser and follows the press level
    a_button_level: assert property (
        s.func == `MFP_FN_BUTTON_IRQ |=> multi_function_pin_oe_out
            && multi_function_pin_out == $past(button_irq_in))
        else $error("Button interrupt not on pin");

    // A single pulse ends on its count, whatever the sources do meanwhile
    a_pulse_ends: assert property (
        s.irq_st == mfp_pkg::MFP_IRQ_HIGH && !s.duration && s.irq_cnt == PULSE_LAST
            |=> s.irq_st == mfp_pkg::MFP_IRQ_IDLE)
        else $error("Single interrupt pulse overran");

endmodule // mfp_pin_ctrl

// ==== hw/mfp_params.svh ====
// Offsets, field positions, reset values, function codes and timing of the multi-function pin
`ifndef MFP_PARAMS_SVH
`define MFP_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define MFP_OFS_PIN_CTRL      7'h62
`define MFP_OFS_RSVD_A        7'h63
`define MFP_OFS_RSVD_B        7'h64
`define MFP_OFS_CLK_SRC       7'h65

// ------------------------------------------------------------
// Field positions of multi_pin_control and of the clock source register
// ------------------------------------------------------------
`define MFP_FLD_FUNC_HI       7
`define MFP_FLD_FUNC_LO       4
`define MFP_FLD_CLK_SEL       3
`define MFP_FLD_DURATION      2
`define MFP_FLD_PIN_LEVEL     1
`define MFP_FLD_GP_VALUE      0
`define MFP_FLD_CORE_SEL      0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MFP_RST_PIN_CTRL      8'h00
`define MFP_RST_CLK_SRC       8'h00
`define MFP_RST_RSVD          8'h00

// ------------------------------------------------------------
// Function select codes
// ------------------------------------------------------------
`define MFP_FN_DISABLED       4'h0
`define MFP_FN_ADC_WCLK       4'h1
`define MFP_FN_DIV1           4'h2
`define MFP_FN_DIV2           4'h3
`define MFP_FN_DIV4           4'h4
`define MFP_FN_DIV8           4'h5
`define MFP_FN_SHORT_IRQ      4'h6
`define MFP_FN_AGC_IRQ        4'h7
`define MFP_FN_GP_IN          4'h8
`define MFP_FN_GP_OUT         4'h9
`define MFP_FN_RESERVED       4'hA
`define MFP_FN_BUS_WCLK       4'hB
`define MFP_FN_BUTTON_IRQ     4'hC
`define MFP_FN_JACK_IRQ_A     4'hD
`define MFP_FN_JACK_IRQ_B     4'hE
`define MFP_FN_ALL_IRQ        4'hF

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define MFP_CLK_KHZ           40000
`define MFP_IRQ_PULSE_US      2000
`define MFP_IRQ_CNT_W         24

`endif

// ==== hw/mfp_pkg.sv ====
// Types shared by the multi-function pin block
`include "mfp_params.svh"

package mfp_pkg;

    // Interrupt pulse generator states
    typedef enum logic [1:0] {
        MFP_IRQ_IDLE,
        MFP_IRQ_HIGH,
        MFP_IRQ_LOW
    } mfp_irq_state_t;

    // Interrupt sources entering the block
    typedef struct packed {
        logic short_circuit;
        logic agc_noise;
        logic headset;
        logic button;
    } mfp_irq_src_t;

    // Two-way pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } mfp_pin_drv_t;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mfp_reg_req_t;

    // Whole state of the block
    typedef struct packed {
        logic [3:0]                 func;
        logic                       clk_sel;
        logic                       duration;
        logic                       gp_value;
        logic                       core_sel;
        logic                       sync1;
        logic                       sync2;
        logic                       clk_prev;
        logic [2:0]                 div_cnt;
        logic                       irq_prev;
        mfp_irq_state_t             irq_st;
        logic [`MFP_IRQ_CNT_W-1:0]  irq_cnt;
        mfp_pin_drv_t               pin;
        logic [7:0]                 rdata;
        logic                       core_clk;
        logic                       wclk_from_pin;
        logic                       button_sticky;
    } mfp_state_t;

endpackage

// ==== dv/mfp_board_model.sv ====
// Board-side model of the multi-function pin
`timescale 1ns/1ps

module mfp_board_model (
    // Device drive
    input  wire logic drv_in,
    input  wire logic oe_in,
    // Board intent
    input  wire logic board_in,
    // Resolved pin level
    output logic      pin_out
);
    // Board drives only after the device lets go, so no contention
    assign pin_out = oe_in ? drv_in : board_in;
endmodule // mfp_board_model

// ==== dv/mfp_pin_ctrl_tb.sv ====
// Self-checking bench of the multi-function pin block
`timescale 1ns/1ps

module mfp_pin_ctrl_tb;
    // ------------------------------------------------------------
    // Stimulus, observation and counters
    // ------------------------------------------------------------
    localparam int PC = 8;
    // Level-routed codes; the divider codes and the reserved code are left out
    localparam logic [3:0] MC [6] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hB, 4'hC};
    localparam logic [3:0] IC [5] = '{4'h6, 4'h7, 4'hD, 4'hE, 4'hF};
    localparam logic [3:0] IM [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h4};
    logic       clk_in, rst_in, wr, rd, fl_rd, bt_rd, mst, brd, prv;
    logic       p_out, p_oe, pin, core, wfp, stk;
    logic [6:0] addr;
    logic [7:0] wd, rdat, v, v2, e;
    logic [3:0] src;   // Short, agc, headset, button
    logic [5:0] ck;    // Pll, divider mux, pll div, bypass, adc wclk, bus wclk
    int         miscompares, num_checks, cyc, n, rises;

    mfp_pin_ctrl #(.PULSE_CYC(PC)) i_mfp_pin_ctrl (
        .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
        .irq_flags_read_in(fl_rd), .button_status_read_in(bt_rd),
        .short_irq_in(src[3]), .agc_noise_irq_in(src[2]), .headset_irq_in(src[1]),
        .button_irq_in(src[0]), .pll_clock_in(ck[0]), .clkdiv_mux_in(ck[1]),
        .pll_divided_clock_in(ck[2]), .bypass_divider_clock_in(ck[3]),
        .adc_word_clock_in(ck[4]), .bus_word_clock_in(ck[5]), .bus_master_in(mst),
        .multi_function_pin_in(pin), .multi_function_pin_out(p_out),
        .multi_function_pin_oe_out(p_oe), .codec_core_clock_input_out(core),
        .word_clock_from_pin_out(wfp), .button_sticky_out(stk));
    mfp_board_model i_mfp_board_model (
        .drv_in(p_out), .oe_in(p_oe), .board_in(brd), .pin_out(pin));

    // ------------------------------------------------------------
    // Clock, edge counter and hang guard
    // ------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Counted on the falling edge, where the pin output has settled
    always @(negedge clk_in) begin
        rises <= rises + int'(p_out & ~prv);
        prv <= p_out;
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] x);
        num_checks++;
        if (s !== x) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_in);
    endtask
    // One strobe cycle, then an idle cycle so strobes never merge
    task automatic wreg(input logic [6:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic rreg(input logic [6:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        tick(1);
        d = rdat;
    endtask
    task automatic hi_cnt(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            if (p_out === 1'b1) n++;
        end
    endtask
    // Expected {oe, out} of the pin for a level-routed code
    function automatic logic [7:0] exp_pin(input logic [3:0] f);
        case (f)
            4'h1: exp_pin = {6'h0, 1'b1, ck[4]};
            4'h9: exp_pin = {6'h0, 1'b1, wd[0]};
            4'hB: exp_pin = {6'h0, mst, mst & ck[5]};
            4'hC: exp_pin = {6'h0, 1'b1, src[0]};
            default: exp_pin = 8'h00;
        endcase
    endfunction
    task automatic end_sim();
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_in, wr, rd, fl_rd, bt_rd, mst, brd} = 7'h40;
        {addr, wd, src, ck} = '0;
        {miscompares, num_checks} = '0;
        void'($urandom(16));
        tick(16);
        rst_in = 1'b0;
        tick(2);
        // Reset values, reserved and unmapped places read zero
        foreach (IM[i]) begin
            rreg(7'h62 + 7'(i), v);
            chk(v, 8'h00);
        end
        // Level-routed codes in turn with random low bits and inputs, and readback of the whole register
        for (int j = 0; j < 14; j++) begin
            v = $urandom;
            {mst, brd, ck, src} = 12'($urandom);
            wreg(7'h62, {MC[j % 6], v[3:0]});
            tick(4);
            e = exp_pin(wd[7:4]);
            chk({6'h0, p_oe, p_oe & p_out}, e);
            chk({7'h0, wfp}, {7'h0, wd[7:4] == 4'hB && !mst && brd});
            rreg(7'h62, v2);
            chk(v2, {wd[7:2], e[1] ? e[0] : brd, wd[0]});
        end
        // Sticky button flag outlives the source until its status read
        src = 4'h1;
        tick(1);
        src = 4'h0;
        tick(5);
        chk({7'h0, stk}, 8'h01);
        bt_rd = 1'b1;
        tick(1);
        bt_rd = 1'b0;
        tick(2);
        chk({7'h0, stk}, 8'h00);
        // Core clock source select and its read-zero upper bits
        repeat (4) begin
            v[0] = ~v[0];
            ck = 6'($urandom);
            wreg(7'h65, {7'h0, v[0]});
            tick(2);
            chk({7'h0, core}, {7'h0, v[0] ? ck[3] : ck[2]});
            rreg(7'h65, v2);
            chk(v2, {7'h0, v[0]});
        end
        // Divided clock: 16 source rises give 16 >> k pin rises
        for (int k = 0; k < 4; k++) begin
            ck = 6'($urandom);
            ck[k[0]] = 1'b0;
            wreg(7'h62, {4'h2 + 4'(k), k[0], 3'b000});
            tick(4);
            n = rises;
            repeat (16) begin
                ck[k[0]] = 1'b1;
                tick(2);
                ck[k[0]] = 1'b0;
                tick(2);
            end
            tick(6);
            chk(8'(rises - n), 8'(16 >> k));
        end
        // Single pulse per interrupt code, each source on its own
        foreach (IC[i]) begin
            src = 4'h0;
            wreg(7'h62, {IC[i], 4'h0});
            tick(4);
            src = IM[i];
            hi_cnt(30);
            chk(8'(n), 8'(PC));
        end
        // Pulse train repeats until the flags read stops it
        src = 4'h0;
        wreg(7'h62, 8'hF4);
        tick(4);
        src = 4'h2;
        tick(21);
        chk({7'h0, p_out}, 8'h01);
        tick(8);
        chk({7'h0, p_out}, 8'h00);
        fl_rd = 1'b1;
        tick(1);
        fl_rd = 1'b0;
        tick(3);
        hi_cnt(30);
        chk(8'(n), 8'h00);
        end_sim();
    end
endmodule // mfp_pin_ctrl_tb
